/* File: design/msrc_pkg.sv */
// Operation
// - Auto enable resets sensor before every acquisition
// - Auto enable is write-only, reads zero
// - Raw select skips user offset correction
// - Factory calibration always applied to outputs
// - Writing one-shot bit starts reset cycle when the sequencer is idle
// - One-shot bit reads one until cycle ends
// - All three control bits reset to zero
// - Active mode acquires periodically, one per sample
`default_nettype none
package msrc_pkg;
  // ---------------------------------------------------------------
  // Register map and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] MSRC_CTRL2_ADDR  = 8'h11;
  localparam int         MSRC_AUTO_BIT    = 7;
  localparam int         MSRC_RAW_BIT     = 5;
  localparam int         MSRC_ONESHOT_BIT = 4;
  localparam logic [7:0] MSRC_CTRL2_RST   = 8'h00;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int MSRC_CLK_NS       = 10;
  localparam int MSRC_RST_CYCLE_NS = 1000;  // Sensor reset pulse length
  localparam int MSRC_RST_CYCLES   =
    (MSRC_RST_CYCLE_NS + MSRC_CLK_NS - 1) / MSRC_CLK_NS;
  localparam int MSRC_SAMPLE_CYCLES = 1000; // Default acquisition period
  localparam int MSRC_CNT_W         = 16;

  // Control fields kept by the register
  typedef struct packed {
    logic auto_en;
    logic raw_sel;
    logic busy;
  } msrc_ctrl_t;

  typedef enum logic [1:0] {
    MSRC_IDLE    = 2'b00,
    MSRC_SRESET  = 2'b01,
    MSRC_ACQUIRE = 2'b10
  } msrc_state_t;
endpackage : msrc_pkg
`default_nettype wire

/* File: design/msrc_pace.sv */
`default_nettype none
// Acquisition pacer: one-cycle tick every period cycles while running
module msrc_pace #(
  parameter int PERIOD = msrc_pkg::MSRC_SAMPLE_CYCLES
) (
  input  wire logic mclk_in,   // Clock
  input  wire logic rst_n_in,  // Sync reset, low
  input  wire logic run_in,    // Active mode
  output logic      tick_out   // Acquisition request
);
  logic [msrc_pkg::MSRC_CNT_W-1:0] cnt_reg, cnt_next;
  logic                            tick_reg, tick_next;

  // ---------------------------------------------------------------
  // Period counter
  // ---------------------------------------------------------------
  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!run_in) begin
      cnt_next = '0;
    end else if (cnt_reg == msrc_pkg::MSRC_CNT_W'(PERIOD - 1)) begin
      cnt_next  = '0;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_out = tick_reg;
endmodule : msrc_pace
`default_nettype wire

/* File: design/msrc_ctrl.sv */
`default_nettype none
// Sensor reset and correction control register with its sequencer
module msrc_ctrl #(
  parameter int SAMPLE_CYCLES = msrc_pkg::MSRC_SAMPLE_CYCLES,
  parameter int RST_CYCLES    = msrc_pkg::MSRC_RST_CYCLES
) (
  input  wire logic       mclk_in,          // Clock, 100 MHz
  input  wire logic       rst_n_in,         // Sync reset, low
  input  wire logic       wr_en_in,         // Register write strobe
  input  wire logic       rd_en_in,         // Register read strobe
  input  wire logic [7:0] addr_in,          // Register address
  input  wire logic [7:0] wdata_in,         // Write data
  input  wire logic       active_mode_select_in, // Periodic acquisition
  input  wire logic [7:0] sample_in,        // Calibrated sample
  input  wire logic [7:0] user_offset_in,   // User offset
  output logic [7:0]      rdata_out,        // Read data
  output logic            sensor_reset_out, // Reset coil drive
  output logic            acquire_out,      // Acquisition pulse
  output logic [7:0]      data_out,         // Output data
  output logic            raw_mode_out      // Raw mode flag
);
  msrc_pkg::msrc_ctrl_t  ctl_reg, ctl_next;
  msrc_pkg::msrc_state_t st_reg, st_next;
  logic [msrc_pkg::MSRC_CNT_W-1:0] cnt_reg, cnt_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] data_reg, data_next;
  logic       srst_reg, srst_next;
  logic       acq_reg, acq_next;
  logic       tick;
  logic       hit_wr;

  msrc_pace #(
    .PERIOD (SAMPLE_CYCLES)
  ) u_pace (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .run_in   (active_mode_select_in),
    .tick_out (tick)
  );

  assign hit_wr = wr_en_in && (addr_in == msrc_pkg::MSRC_CTRL2_ADDR);

  // ---------------------------------------------------------------
  // Register and sequencer next state
  // ---------------------------------------------------------------
  // A tick that lands mid reset is dropped, as ticks are only taken in the idle state, so an
  // acquisition is never taken while the coil is still pulsed.
  always_comb begin
    ctl_next   = ctl_reg;
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    srst_next  = 1'b0;
    acq_next   = 1'b0;
    data_next  = data_reg;
    rdata_next = rdata_reg;
    if (hit_wr) begin
      ctl_next.auto_en = wdata_in[msrc_pkg::MSRC_AUTO_BIT];
      ctl_next.raw_sel = wdata_in[msrc_pkg::MSRC_RAW_BIT];
    end
    unique case (st_reg)
      msrc_pkg::MSRC_IDLE: begin
        if (hit_wr && wdata_in[msrc_pkg::MSRC_ONESHOT_BIT]) begin
          st_next       = msrc_pkg::MSRC_SRESET;
          ctl_next.busy = 1'b1;
          cnt_next      = '0;
        end else if (tick) begin
          if (ctl_next.auto_en) begin
            st_next       = msrc_pkg::MSRC_ACQUIRE;
            ctl_next.busy = 1'b0;
            cnt_next      = '0;
          end else begin
            acq_next = 1'b1;
          end
        end
      end
      msrc_pkg::MSRC_SRESET: begin
        // Count one step past the pulse, so the coil is high for the
        // full RST_CYCLES and busy drops on the same edge as the coil
        srst_next = 1'b1;
        cnt_next  = cnt_reg + 1'b1;
        if (cnt_reg == msrc_pkg::MSRC_CNT_W'(RST_CYCLES)) begin
          st_next       = msrc_pkg::MSRC_IDLE;
          ctl_next.busy = 1'b0;
          srst_next     = 1'b0;
        end
      end
      msrc_pkg::MSRC_ACQUIRE: begin
        // Auto reset pulse, then the acquisition itself
        srst_next = 1'b1;
        cnt_next  = cnt_reg + 1'b1;
        if (cnt_reg == msrc_pkg::MSRC_CNT_W'(RST_CYCLES)) begin
          st_next   = msrc_pkg::MSRC_IDLE;
          srst_next = 1'b0;
          acq_next  = 1'b1;
        end
      end
      default: begin
        st_next = msrc_pkg::MSRC_IDLE;
      end
    endcase
    // Sample is already factory calibrated; only user offset is optional
    if (acq_reg) begin
      data_next = ctl_reg.raw_sel ? sample_in
                                  : sample_in - user_offset_in;
    end
    if (rd_en_in) begin
      if (addr_in == msrc_pkg::MSRC_CTRL2_ADDR) begin
        rdata_next = msrc_pkg::MSRC_CTRL2_RST;
        rdata_next[msrc_pkg::MSRC_RAW_BIT]     = ctl_reg.raw_sel;
        rdata_next[msrc_pkg::MSRC_ONESHOT_BIT] = ctl_reg.busy;
      end else begin
        rdata_next = msrc_pkg::MSRC_CTRL2_RST;
      end
    end
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ctl_reg   <= '0;
      st_reg    <= msrc_pkg::MSRC_IDLE;
      cnt_reg   <= '0;
      srst_reg  <= 1'b0;
      acq_reg   <= 1'b0;
      data_reg  <= '0;
      rdata_reg <= msrc_pkg::MSRC_CTRL2_RST;
    end else begin
      ctl_reg   <= ctl_next;
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      srst_reg  <= srst_next;
      acq_reg   <= acq_next;
      data_reg  <= data_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_out        = rdata_reg;
  assign sensor_reset_out = srst_reg;
  assign acquire_out      = acq_reg;
  assign data_out         = data_reg;
  assign raw_mode_out     = ctl_reg.raw_sel;
endmodule : msrc_ctrl
`default_nettype wire

/* File: dv/msrc_chk.sv */
`default_nettype none
// Port checks for the sensor reset control register
module msrc_chk #(parameter int RST_CYCLES = 4) (
  input wire logic       mclk_in,               // Clock
  input wire logic       rst_n_in,              // Reset
  input wire logic       wr_en_in,              // Write
  input wire logic [7:0] addr_in,               // Address
  input wire logic [7:0] wdata_in,              // Data
  input wire logic       active_mode_select_in, // Mode
  input wire logic [7:0] rdata_out,             // Read data
  input wire logic       sensor_reset_out,      // Coil
  input wire logic       acquire_out,           // Sample
  input wire logic       raw_mode_out           // Raw
);
  wire logic  reg_wr = wr_en_in && addr_in == 8'h11;
  wire logic  one_wr = reg_wr && wdata_in[4];
  logic       auto_reg, auto_next;
  logic [7:0] hi_reg, hi_next, gap_reg, gap_next;
  // Enable reads back zero, so it is mirrored here from the writes
  always_comb begin
    auto_next = reg_wr ? wdata_in[7] : auto_reg;
    hi_next   = sensor_reset_out ? hi_reg + 8'h01 : 8'h00;
    gap_next  = sensor_reset_out ? 8'h00 : gap_reg + {7'h00, ~&gap_reg};
  end
  always_ff @(posedge mclk_in) begin
    auto_reg <= rst_n_in && auto_next;
    hi_reg   <= rst_n_in ? hi_next : 8'h00;
    gap_reg  <= rst_n_in ? gap_next : 8'hff;
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_manual;
    one_wr && !sensor_reset_out && !active_mode_select_in;
  endsequence
  a_reset_clear: assert property ($rose(rst_n_in) |->
    !raw_mode_out && !sensor_reset_out && rdata_out == 8'h00)
    else $error("state not cleared");
  a_auto_rd_zero: assert property (!rdata_out[7])
    else $error("auto bit read");
  a_unused_zero: assert property (rdata_out[6] == 1'b0 &&
    rdata_out[3:0] == 4'h0) else $error("unused bits set");
  a_raw_follow: assert property (reg_wr |=>
    raw_mode_out == $past(wdata_in[5])) else $error("raw bit");
  a_manual_go: assert property (s_manual |-> ##[1:3] sensor_reset_out)
    else $error("no reset pulse");
  a_pulse_len: assert property ($fell(sensor_reset_out) |->
    hi_reg == RST_CYCLES) else $error("pulse length");
  a_auto_first: assert property (acquire_out && auto_reg |->
    gap_reg < 8'h08) else $error("no reset before sample");
  a_auto_off: assert property ($rose(sensor_reset_out) && !auto_reg |->
    $past(one_wr) || $past(one_wr, 2) || $past(one_wr, 3))
    else $error("stray reset");
endmodule : msrc_chk
bind msrc_ctrl msrc_chk #(.RST_CYCLES(RST_CYCLES)) msrc_chk_inst (.mclk_in,
  .rst_n_in, .wr_en_in, .addr_in, .wdata_in, .active_mode_select_in,
  .rdata_out, .sensor_reset_out, .acquire_out, .raw_mode_out);
`default_nettype wire

/* File: dv/msrc_host.sv */
`default_nettype none
// Host on the register port; strobes move on the falling edge
module msrc_host (
  input  wire logic       clk_in, // Clock
  input  wire logic [7:0] rd_in,  // Read data
  output logic            wr_out, // Write strobe
  output logic            rd_out, // Read strobe
  output logic      [7:0] a_out,  // Address
  output logic      [7:0] d_out   // Write data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {wr_out, rd_out, a_out, d_out} = 18'h0_0000;
  // One access; released strobes drop to zero, address and data show inverted values, never the old ones
  task automatic access(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q);
    @(negedge clk_in);
    {wr_out, rd_out, a_out, d_out} = {w, ~w, a, d};
    @(negedge clk_in);
    q = rd_in;
    {wr_out, rd_out, a_out, d_out} = {2'h0, ~a, ~d};
  endtask : access
endmodule : msrc_host
`default_nettype wire

/* File: dv/tb.sv */
`default_nettype none
// Self-checking bench for the sensor reset control register
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk_in = 1'b0, rst_n_in = 1'b0, active_mode_select_in = 1'b0;
  logic [7:0] sample_in = 8'h50, user_offset_in = 8'h10;
  logic [7:0] rdata_out, data_out, addr_in, wdata_in, q;
  logic       wr_en_in, rd_en_in, sensor_reset_out, acquire_out, raw_mode_out;
  int         bad_count = 0, num_checks = 0, cycles = 0;
  always #5 mclk_in = ~mclk_in;
  msrc_ctrl #(.SAMPLE_CYCLES(20), .RST_CYCLES(4)) msrc_ctrl_inst (.mclk_in,
    .rst_n_in, .wr_en_in, .rd_en_in, .addr_in, .wdata_in,
    .active_mode_select_in, .sample_in, .user_offset_in, .rdata_out,
    .sensor_reset_out, .acquire_out, .data_out, .raw_mode_out);
  msrc_host msrc_host_inst (.clk_in(mclk_in), .rd_in(rdata_out),
    .wr_out(wr_en_in), .rd_out(rd_en_in), .a_out(addr_in), .d_out(wdata_in));
  // Case equality, so an unknown never passes
  task automatic check(input string n, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic give_verdict;
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // Data lands the cycle after the acquisition pulse
  // A missing pulse or a wrong coil history is a mismatch of its own
  task automatic acq(input logic [7:0] e, input logic rs);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 99 && acquire_out !== 1'b1; i++) begin
      seen = seen | sensor_reset_out;
      @(negedge mclk_in);
    end
    check("acquire_out", 8'h01, {7'h00, acquire_out});
    check("reset seen", {7'h00, rs}, {7'h00, seen});
    @(negedge mclk_in);
    check("data_out", e, data_out);
  endtask : acq
  // Watchdog; the run needs only about a hundred cycles
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(negedge mclk_in);
    rst_n_in = 1'b1;
    msrc_host_inst.access(1'b0, 8'h11, 8'h00, q);
    check("ctrl reset", 8'h00, q);
    msrc_host_inst.access(1'b1, 8'h11, 8'hef, q);
    msrc_host_inst.access(1'b1, 8'h12, 8'h00, q);
    msrc_host_inst.access(1'b0, 8'h11, 8'h00, q);
    check("ctrl masked", 8'h20, q);
    check("raw_mode_out", 8'h01, {7'h00, raw_mode_out});
    msrc_host_inst.access(1'b0, 8'h12, 8'h00, q);
    check("unmapped", 8'h00, q);
    msrc_host_inst.access(1'b1, 8'h11, 8'h30, q);
    msrc_host_inst.access(1'b0, 8'h11, 8'h00, q);
    check("ctrl busy", 8'h30, q);
    repeat (8) @(negedge mclk_in);
    msrc_host_inst.access(1'b0, 8'h11, 8'h00, q);
    check("ctrl idle", 8'h20, q);
    msrc_host_inst.access(1'b1, 8'h11, 8'ha0, q);
    active_mode_select_in = 1'b1;
    acq(8'h50, 1'b1);
    msrc_host_inst.access(1'b1, 8'h11, 8'h80, q);
    acq(8'h40, 1'b1);
    msrc_host_inst.access(1'b1, 8'h11, 8'h00, q);
    acq(8'h40, 1'b0);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
